// *** hdl/pulse_decoder_pkg.sv ***
// constants and types shared by the pulse programming decoder
package pulse_decoder_pkg;
  localparam int unsigned CLK_MHZ      = 20;
  localparam int unsigned T_LOW_US     = 40;
  localparam int unsigned T_ACTIVE_US  = 40;
  localparam int unsigned T_BLOW_US    = 40;
  localparam int unsigned T_LONG_US    = 400;
  localparam int unsigned LOW_CYC      = T_LOW_US * CLK_MHZ;
  localparam int unsigned ACTIVE_CYC   = T_ACTIVE_US * CLK_MHZ;
  localparam int unsigned BLOW_CYC     = T_BLOW_US * CLK_MHZ;
  localparam int unsigned LONG_CYC     = T_LONG_US * CLK_MHZ;
  localparam int unsigned RUN_W        = 16;
  localparam int unsigned KEY_W        = 4;
  localparam logic [3:0]  KEY_SENS     = 4'h1;
  localparam logic [3:0]  KEY_FINE     = 4'h1;
  localparam logic [3:0]  KEY_COARSE   = 4'h2;
  localparam logic [3:0]  KEY_LOCK     = 4'h3;
  localparam logic [7:0]  SETTING_INIT = 8'h00;

  typedef enum {LVL_LOW, LVL_MID, LVL_HIGH} level_t;
  typedef enum {ST_Z1_IDLE, ST_Z1_KEY, ST_Z1_CODE, ST_Z2_KEY, ST_Z2_CODE, ST_DONE, ST_LOCKED} prog_state_t;
endpackage

// *** hdl/pulse_evt_if.sv ***
// qualified pulse events between the level detector and the decoder
`timescale 1ns/1ps
interface pulse_evt_if;
  logic mid_evt;
  logic high_evt;
  logic long_evt;
  modport src (output mid_evt, output high_evt, output long_evt);
  modport dst (input mid_evt, input high_evt, input long_evt);
endinterface

// *** hdl/pulse_level_detector.sv ***
// three-level pin classifier and pulse timing qualifier
`timescale 1ns/1ps
module pulse_level_detector
  import pulse_decoder_pkg::*;
#(
  parameter int unsigned LONG_CYCLES = LONG_CYC
) (
  input  wire logic   core_clk_i,
  input  wire logic   rst_n_i,
  input  wire logic   mid_cmp_i,
  input  wire logic   high_cmp_i,
  pulse_evt_if.src    evt
);
  logic [2:0]       mid_sync_reg;
  logic [2:0]       high_sync_reg;
  logic             mid_st_reg;
  logic             high_st_reg;
  level_t           level;
  level_t           peak_reg;
  logic [RUN_W-1:0] run_cnt_reg;
  logic             active_reg;
  logic             gap_ok_reg;
  logic             mid_evt_reg;
  logic             high_evt_reg;
  logic             long_evt_reg;
  logic             rise;
  logic             fall;
  logic             qualified;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mid_sync_reg  <= 3'h0;
      high_sync_reg <= 3'h0;
    end else begin
      mid_sync_reg  <= {mid_sync_reg[1:0], mid_cmp_i};
      high_sync_reg <= {high_sync_reg[1:0], high_cmp_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mid_st_reg  <= 1'b0;
      high_st_reg <= 1'b0;
    end else begin
      if (mid_sync_reg[1] == mid_sync_reg[2]) mid_st_reg <= mid_sync_reg[2];
      if (high_sync_reg[1] == high_sync_reg[2]) high_st_reg <= high_sync_reg[2];
    end
  end

  always_comb begin
    if (high_st_reg) level = LVL_HIGH;
    else if (mid_st_reg) level = LVL_MID;
    else level = LVL_LOW;
  end

  assign rise      = !active_reg && (level != LVL_LOW);
  assign fall      = active_reg && (level == LVL_LOW);
  assign qualified = gap_ok_reg && (run_cnt_reg >= RUN_W'(ACTIVE_CYC));

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      active_reg  <= 1'b0;
      run_cnt_reg <= '0;
      gap_ok_reg  <= 1'b0;
      peak_reg    <= LVL_LOW;
    end else begin
      if (rise || fall) begin
        active_reg  <= rise;
        run_cnt_reg <= RUN_W'(1);
      end else if (run_cnt_reg != '1) begin
        run_cnt_reg <= run_cnt_reg + RUN_W'(1);
      end
      if (rise) begin
        gap_ok_reg <= (run_cnt_reg >= RUN_W'(LOW_CYC));
        peak_reg   <= level;
      end else if (active_reg && level == LVL_HIGH) begin
        peak_reg <= LVL_HIGH;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      mid_evt_reg  <= 1'b0;
      high_evt_reg <= 1'b0;
      long_evt_reg <= 1'b0;
    end else begin
      // mid counted on return to low
      mid_evt_reg  <= fall && qualified && (peak_reg == LVL_MID);
      high_evt_reg <= fall && qualified && (peak_reg == LVL_HIGH);
      // long high is a blow pulse
      long_evt_reg <= fall && qualified && (peak_reg == LVL_HIGH) && (run_cnt_reg >= RUN_W'(LONG_CYCLES));
    end
  end

  assign evt.mid_evt  = mid_evt_reg;
  assign evt.high_evt = high_evt_reg;
  assign evt.long_evt = long_evt_reg;

  evt_exclusive_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !(mid_evt_reg && high_evt_reg)) else $error("mid and high event together");
  short_pulse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (fall && run_cnt_reg < RUN_W'(ACTIVE_CYC)) |=> !(mid_evt_reg || high_evt_reg))
    else $error("short pulse produced an event");
  short_gap_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (fall && !gap_ok_reg) |=> !(mid_evt_reg || high_evt_reg)) else $error("short gap produced an event");
  long_is_high_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    long_evt_reg |-> high_evt_reg) else $error("blow event without high event");
endmodule

// *** hdl/pulse_programming_decoder.sv ***
// pulse train decoder: zones, keys, codes, activated and blown settings
`timescale 1ns/1ps
module pulse_programming_decoder
  import pulse_decoder_pkg::*;
#(
  parameter int unsigned SENS_W      = 8,
  parameter int unsigned FINE_W      = 8,
  parameter int unsigned COARSE_W    = 8,
  parameter int unsigned LONG_CYCLES = LONG_CYC
) (
  input  wire logic                core_clk_i,
  input  wire logic                rst_n_i,
  input  wire logic                mid_cmp_i,
  input  wire logic                high_cmp_i,
  input  wire logic                factory_clear_i,
  output logic [SENS_W-1:0]        sens_value_o,
  output logic [FINE_W-1:0]        fine_value_o,
  output logic [COARSE_W-1:0]      coarse_value_o,
  output logic                     locked_o,
  output logic [1:0]               zone_o,
  output logic                     reject_o,
  output logic                     fuse_burn_o
);
  pulse_evt_if evt_bus ();

  prog_state_t         state_reg;
  logic [KEY_W-1:0]    key_reg;
  logic [1:0]          sel_reg;
  logic [7:0]          code_reg;
  logic [SENS_W-1:0]   act_sens_reg;
  logic [FINE_W-1:0]   act_fine_reg;
  logic [COARSE_W-1:0] act_coarse_reg;
  logic [SENS_W-1:0]   fuse_sens_reg;
  logic [FINE_W-1:0]   fuse_fine_reg;
  logic [COARSE_W-1:0] fuse_coarse_reg;
  logic                fuse_lock_reg;
  logic                reject_reg;
  logic                burn_reg;
  logic [7:0]          code_max;
  logic                one_bit;
  logic                blow_ok;

  localparam logic [1:0] SEL_NONE   = 2'h0;
  localparam logic [1:0] SEL_SENS   = 2'h1;
  localparam logic [1:0] SEL_FINE   = 2'h2;
  localparam logic [1:0] SEL_COARSE = 2'h3;

  pulse_level_detector #(
    .LONG_CYCLES (LONG_CYCLES)
  ) u_detector (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .mid_cmp_i  (mid_cmp_i),
    .high_cmp_i (high_cmp_i),
    .evt        (evt_bus.src)
  );

  // largest code the register of a selection holds
  function automatic logic [7:0] max_code(input logic [1:0] sel, input logic zone2);
    logic [7:0] m;
    m = 8'h00;
    case (sel)
      SEL_SENS:   m = 8'((1 << SENS_W) - 1);
      SEL_FINE:   m = 8'((1 << FINE_W) - 1);
      SEL_COARSE: m = 8'((1 << COARSE_W) - 1);
      default:    m = zone2 ? 8'h01 : 8'h00;
    endcase
    return m;
  endfunction

  // register chosen by zone and key
  function automatic logic [1:0] decode_key(input logic zone2, input logic [KEY_W-1:0] key);
    logic [1:0] s;
    s = SEL_NONE;
    if (!zone2 && key == KEY_SENS) s = SEL_SENS;
    else if (zone2 && key == KEY_FINE) s = SEL_FINE;
    else if (zone2 && key == KEY_COARSE) s = SEL_COARSE;
    return s;
  endfunction

  // lock register holds one bit, reachable only behind its key in zone two; kept in done so the code stays in range
  assign code_max = max_code(sel_reg, key_reg == KEY_LOCK && (state_reg == ST_Z2_CODE || state_reg == ST_DONE));
  assign one_bit  = (code_reg != 8'h00) && ((code_reg & (code_reg - 8'h01)) == 8'h00);
  assign blow_ok  = one_bit && (sel_reg != SEL_NONE || key_reg == KEY_LOCK);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg  <= ST_Z1_IDLE;
      key_reg    <= '0;
      sel_reg    <= SEL_NONE;
      code_reg   <= 8'h00;
      reject_reg <= 1'b0;
      burn_reg   <= 1'b0;
    end else begin
      reject_reg <= 1'b0;
      burn_reg   <= 1'b0;
      case (state_reg)
        ST_Z1_IDLE: begin
          if (fuse_lock_reg && (evt_bus.mid_evt || evt_bus.high_evt)) begin
            state_reg  <= ST_LOCKED;
            reject_reg <= 1'b1;
          end else if (evt_bus.high_evt) begin
            state_reg <= ST_Z1_KEY;
          end else if (evt_bus.mid_evt) begin
            reject_reg <= 1'b1;
          end
        end
        ST_Z1_KEY, ST_Z2_KEY: begin
          if (evt_bus.mid_evt && key_reg != '1) begin
            key_reg <= key_reg + KEY_W'(1);
          end else if (evt_bus.high_evt) begin
            sel_reg   <= decode_key(state_reg == ST_Z2_KEY, key_reg);
            code_reg  <= 8'h00;
            state_reg <= (state_reg == ST_Z1_KEY) ? ST_Z1_CODE : ST_Z2_CODE;
          end
        end
        ST_Z1_CODE, ST_Z2_CODE: begin
          if (evt_bus.mid_evt) begin
            if (code_reg < code_max) code_reg <= code_reg + 8'h01;
          end else if (evt_bus.long_evt) begin
            // single bit per blow, then power cycle
            burn_reg   <= blow_ok;
            reject_reg <= !blow_ok;
            state_reg  <= ST_DONE;
          end else if (evt_bus.high_evt && state_reg == ST_Z1_CODE) begin
            key_reg   <= '0;
            state_reg <= ST_Z2_KEY;
          end else if (evt_bus.high_evt) begin
            reject_reg <= 1'b1;
            state_reg  <= ST_DONE;
          end
        end
        ST_DONE, ST_LOCKED: begin
          reject_reg <= evt_bus.mid_evt || evt_bus.high_evt;
        end
        default: state_reg <= ST_Z1_IDLE;
      endcase
    end
  end

  // activated value follows the code at once
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      act_sens_reg   <= SENS_W'(SETTING_INIT);
      act_fine_reg   <= FINE_W'(SETTING_INIT);
      act_coarse_reg <= COARSE_W'(SETTING_INIT);
    end else if ((state_reg == ST_Z1_CODE || state_reg == ST_Z2_CODE) && evt_bus.mid_evt
                 && code_reg < code_max) begin
      // each selected register keeps its own temporary setting
      case (sel_reg)
        SEL_SENS:   act_sens_reg   <= SENS_W'(code_reg + 8'h01);
        SEL_FINE:   act_fine_reg   <= FINE_W'(code_reg + 8'h01);
        SEL_COARSE: act_coarse_reg <= COARSE_W'(code_reg + 8'h01);
        default:    act_sens_reg   <= act_sens_reg;
      endcase
    end
  end

  // fuses survive power cycles, only set; factory_clear_i clears them
  always_ff @(posedge core_clk_i) begin
    if (factory_clear_i) begin
      fuse_sens_reg   <= '0;
      fuse_fine_reg   <= '0;
      fuse_coarse_reg <= '0;
      fuse_lock_reg   <= 1'b0;
    end else if (rst_n_i && (state_reg == ST_Z1_CODE || state_reg == ST_Z2_CODE)
                 && evt_bus.long_evt && blow_ok) begin
      case (sel_reg)
        SEL_SENS:   fuse_sens_reg   <= fuse_sens_reg | SENS_W'(code_reg);
        SEL_FINE:   fuse_fine_reg   <= fuse_fine_reg | FINE_W'(code_reg);
        SEL_COARSE: fuse_coarse_reg <= fuse_coarse_reg | COARSE_W'(code_reg);
        default:    fuse_lock_reg   <= 1'b1;
      endcase
    end
  end

  // registers not addressed since power-up show only their fuses
  assign sens_value_o   = fuse_sens_reg | act_sens_reg;
  assign fine_value_o   = fuse_fine_reg | act_fine_reg;
  assign coarse_value_o = fuse_coarse_reg | act_coarse_reg;
  assign locked_o       = fuse_lock_reg;
  assign reject_o       = reject_reg;
  assign fuse_burn_o    = burn_reg;
  assign zone_o = (state_reg == ST_Z2_KEY || state_reg == ST_Z2_CODE) ? 2'h2 :
                  (state_reg == ST_Z1_KEY || state_reg == ST_Z1_CODE) ? 2'h1 : 2'h0;

  zone_order_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_Z2_KEY && $past(state_reg) != ST_Z2_KEY) |-> $past(state_reg) == ST_Z1_CODE)
    else $error("zone two entered without leaving zone one");
  code_sat_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    code_reg <= code_max) else $error("code above register maximum");
  code_step_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_Z1_CODE && evt_bus.mid_evt && code_reg < code_max) |=> code_reg == $past(code_reg) + 8'h01)
    else $error("code did not step by one");
  lock_refuse_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (fuse_lock_reg && state_reg == ST_Z1_IDLE && evt_bus.high_evt) |=> state_reg == ST_LOCKED && reject_o)
    else $error("locked device accepted programming");
  fuse_keep_a: assert property (@(posedge core_clk_i) disable iff (factory_clear_i)
    (fuse_sens_reg & $past(fuse_sens_reg)) == $past(fuse_sens_reg)) else $error("blown fuse cleared");
  burn_single_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    fuse_burn_o |-> state_reg == ST_DONE ##1 !fuse_burn_o) else $error("blow not single");
  third_pair_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (state_reg == ST_Z2_CODE && evt_bus.high_evt && !evt_bus.long_evt) |=> state_reg == ST_DONE && reject_o)
    else $error("third key-code accepted");
  reset_entry_a: assert property (@(posedge core_clk_i)
    !rst_n_i |=> state_reg == ST_Z1_IDLE && code_reg == 8'h00 && key_reg == '0) else $error("bad power-up state");
endmodule

// *** tb/pulse_programmer_model.sv ***
// programming station model driving the pin level comparators
`timescale 1ns/1ps
module pulse_programmer_model #(
  parameter int unsigned GAP_CYC = 820
) (
  input  wire logic core_clk_i,
  output logic      mid_cmp_o,
  output logic      high_cmp_o
);
  initial begin
    mid_cmp_o  = 1'b0;
    high_cmp_o = 1'b0;
  end

  // chosen low gap, then one pulse
  task automatic drive_gap(input logic hi, input int unsigned gap, input int unsigned act);
    repeat (gap) @(negedge core_clk_i);
    // low, active level, back to low
    mid_cmp_o  <= 1'b1;
    high_cmp_o <= hi;
    repeat (act) @(negedge core_clk_i);
    mid_cmp_o  <= 1'b0;
    high_cmp_o <= 1'b0;
  endtask

  // legal low gap before every pulse
  task automatic drive(input logic hi, input int unsigned act);
    drive_gap(hi, GAP_CYC, act);
  endtask
endmodule

// *** tb/tb_pulse_programming_decoder.sv ***
// self-checking bench for the pulse programming decoder
`timescale 1ns/1ps
module tb_pulse_programming_decoder;
  import pulse_decoder_pkg::*;
  localparam int unsigned LONG_SIM = 1000;
  localparam int unsigned ACT      = 820;
  localparam int unsigned SHORT    = 400;
  localparam int unsigned BLOW     = 1100;
  logic        core_clk_i;
  logic        rst_n_i;
  logic        factory_clear_i;
  logic        mid_cmp_i;
  logic        high_cmp_i;
  logic [1:0]  sens_value_o;
  logic [7:0]  fine_value_o;
  logic [7:0]  coarse_value_o;
  logic        locked_o;
  logic [1:0]  zone_o;
  logic        reject_o;
  logic        fuse_burn_o;
  logic [31:0] exp_q[$];
  logic [31:0] prev_s;
  logic [7:0]  e_act[1:3];
  logic [7:0]  e_blown[1:3];
  logic [7:0]  max_val[1:3];
  logic        e_lock;
  logic [1:0]  e_zone;
  logic        run_q;
  logic        run_qq;
  int          tgt;
  int          k;
  int          seed;
  int          n_fail;
  int          checks_done;
  wire  [31:0] cur_s = {3'h0, 6'h00, sens_value_o, fine_value_o, coarse_value_o, locked_o, zone_o, reject_o,
                        fuse_burn_o};

  pulse_programming_decoder #(.SENS_W(2), .FINE_W(8), .COARSE_W(8), .LONG_CYCLES(LONG_SIM)) u_pulse_programming_decoder (
    .core_clk_i      (core_clk_i),
    .rst_n_i         (rst_n_i),
    .mid_cmp_i       (mid_cmp_i),
    .high_cmp_i      (high_cmp_i),
    .factory_clear_i (factory_clear_i),
    .sens_value_o    (sens_value_o),
    .fine_value_o    (fine_value_o),
    .coarse_value_o  (coarse_value_o),
    .locked_o        (locked_o),
    .zone_o          (zone_o),
    .reject_o        (reject_o),
    .fuse_burn_o     (fuse_burn_o)
  );

  pulse_programmer_model u_pulse_programmer_model (
    .core_clk_i (core_clk_i),
    .mid_cmp_o  (mid_cmp_i),
    .high_cmp_o (high_cmp_i)
  );

  initial core_clk_i = 1'b0;
  always #25 core_clk_i = ~core_clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("fails %0d checks %0d", n_fail, checks_done);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  function automatic logic [31:0] expect_s(input logic rej, input logic burn);
    return {3'h0, e_blown[1] | e_act[1], e_blown[2] | e_act[2], e_blown[3] | e_act[3], e_lock, e_zone, rej, burn};
  endfunction

  task automatic note(input logic rej, input logic burn);
    exp_q.push_back(expect_s(rej, burn));
  endtask

  task automatic hp(input int unsigned len);
    u_pulse_programmer_model.drive(1'b1, len);
  endtask

  task automatic mp(input int unsigned n);
    repeat (n) u_pulse_programmer_model.drive(1'b0, ACT);
  endtask

  // code mids: one step each, saturating, noted only when a value moves
  task automatic code(input int unsigned n);
    logic [7:0] old;
    for (int i = 0; i < n; i++) begin
      if (tgt != 0 && e_act[tgt] < max_val[tgt]) begin
        old = e_blown[tgt] | e_act[tgt];
        e_act[tgt] = e_act[tgt] + 8'h01;
        if ((e_blown[tgt] | e_act[tgt]) != old) note(1'b0, 1'b0);
      end
      mp(1);
    end
  endtask

  task automatic power_cycle;
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b0;
    repeat (4) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    e_act  = '{default: 8'h00};
    e_zone = 2'h0;
    tgt    = 0;
    @(negedge core_clk_i);
    check(cur_s, expect_s(1'b0, 1'b0));
  endtask

  task automatic enter_sens;
    e_zone = 2'h1;
    note(1'b0, 1'b0);
    hp(ACT);
    mp(1);
    hp(ACT);
    tgt = 1;
  endtask

  // result watcher: every output event takes the oldest note
  always @(posedge core_clk_i) begin
    run_q  <= rst_n_i;
    run_qq <= run_q;
  end
  always @(negedge core_clk_i) begin
    if (run_q && run_qq && (cur_s[31:2] !== prev_s[31:2] || reject_o === 1'b1 || fuse_burn_o === 1'b1)) begin
      if (exp_q.size() == 0) check(cur_s, 32'hxxxxxxxx);
      else check(cur_s, exp_q.pop_front());
    end
    prev_s <= cur_s;
  end

  initial begin
    repeat (90000) @(posedge core_clk_i);
    n_fail++;
    stop_test();
  end

  initial begin
    seed            = 32'h3d17c5a6;
    n_fail          = 0;
    checks_done     = 0;
    rst_n_i         = 1'b0;
    factory_clear_i = 1'b1;
    e_act           = '{default: 8'h00};
    e_blown         = '{default: 8'h00};
    max_val         = '{8'h03, 8'hff, 8'hff};
    e_lock          = 1'b0;
    e_zone          = 2'h0;
    tgt             = 0;
    repeat (3) @(negedge core_clk_i);
    factory_clear_i = 1'b0;
    rst_n_i         = 1'b1;
    @(negedge core_clk_i);
    check(cur_s, 32'h00000000);
    note(1'b1, 1'b0);
    mp(1);
    enter_sens();
    u_pulse_programmer_model.drive(1'b0, SHORT);
    u_pulse_programmer_model.drive_gap(1'b0, SHORT, ACT);
    code(5);
    e_zone = 2'h2;
    note(1'b0, 1'b0);
    hp(ACT);
    k = {$random(seed)} % 2 + 1;
    mp(k);
    hp(ACT);
    tgt = k + 1;
    code({$random(seed)} % 3 + 1);
    e_zone = 2'h0;
    note(1'b1, 1'b0);
    hp(ACT);
    power_cycle();
    enter_sens();
    code(2);
    e_blown[1] = 8'h02;
    e_zone = 2'h0;
    note(1'b0, 1'b1);
    hp(BLOW);
    note(1'b1, 1'b0);
    mp(1);
    power_cycle();
    enter_sens();
    code(1);
    e_blown[1] = 8'h03;
    e_zone = 2'h0;
    note(1'b0, 1'b1);
    hp(BLOW);
    power_cycle();
    enter_sens();
    code(1);
    e_zone = 2'h2;
    note(1'b0, 1'b0);
    hp(ACT);
    mp(3);
    hp(ACT);
    tgt = 0;
    code(1);
    e_lock = 1'b1;
    e_zone = 2'h0;
    note(1'b0, 1'b1);
    hp(BLOW);
    power_cycle();
    note(1'b1, 1'b0);
    hp(ACT);
    repeat (20) @(negedge core_clk_i);
    check(32'(exp_q.size()), 32'h00000000);
    stop_test();
  end
endmodule
